// File: common/mmsp_pkg.sv
// Constants and types shared by the status and page-check block
// How it works
// - Status read shows last enabled user in bits 0,13: 00 A, 01 B, 10 C.
// - Status bit 1 is one while translation is active, else zero.
// - Bits 2,3,4 record last fault: I/O, write, indirect protection.
// - Bit 5 set when last map reference came from single-cycle mode.
// - Bits 6-8 show which map the next table load writes.
// - Bits 9-12 show load-effective, I/O, write, indirect protection of last user.
// - Bit 14 set when data channel translation is enabled.
// - Bit 15 set when last I/O interrupt arrived while translating.
// - Page-check select stores logical page bits 1-5 and map code 6-8.
// - Page-check read returns physical page of selected page in bits 6-15.
// - Result bit 0 write-protect, bits 1-3 map code, bits 4-5 zero.
// - Write-protect plus all physical bits one marks page invalid.
// - Untranslated, only logical page 31 is remapped; others pass through.
// - Page-31 load only with translation off; takes bits 6-15.
// - Changed page-31 target applies to the very next fetch.
// - I/O reset restores page 31 to identity translation.
// - I/O reset clears status bits 0-5, 13-15 and stops translation.
// - Interrupts held off from single-cycle until next load/store completes.
// - Single-cycle in user mode without LOAD_EFFECTIVE_MODE or I/O protection stops translation.
// - Single-cycle while untranslated maps only the next load/store first reference.
// - That reference uses the user map named by status bits 0,13 then.
// - Only the first indirection level is translated; the second is not.
package mmsp_pkg;
  // ==========================================================
  // Sizes
  localparam int PAGE_W = 5;
  localparam int PHYS_W = 10;
  localparam int OFFS_W = 10;
  localparam int MAP_W = 3;
  localparam int ENTRY_W = PHYS_W + 1;
  // ==========================================================
  // Status word vector positions (documented bit n sits at 15-n)
  localparam int ST_USER_HI = 15;
  localparam int ST_XLATE = 14;
  localparam int ST_FIO = 13;
  localparam int ST_FWP = 12;
  localparam int ST_FIND = 11;
  localparam int ST_SC = 10;
  localparam int ST_MAP_HI = 9;
  localparam int ST_MAP_LO = 7;
  localparam int ST_LEF = 6;
  localparam int ST_IOP = 5;
  localparam int ST_WPE = 4;
  localparam int ST_INDE = 3;
  localparam int ST_USER_LO = 2;
  localparam int ST_DCH = 1;
  localparam int ST_UM = 0;
  localparam int ST_UE = 0;
  // ==========================================================
  // Page-check select, result and table-word fields
  localparam int PG_HI = 14;
  localparam int PG_LO = 10;
  localparam int RES_WP = 15;
  localparam int RES_MAP_HI = 14;
  localparam int RES_MAP_LO = 12;
  localparam int WORD_WP = 15;
  localparam int PHYS_HI = 9;
  // ==========================================================
  // Reset values
  localparam logic [PHYS_W-1:0] P31_RESET = 10'h01F;
  localparam logic [PAGE_W-1:0] P31_PAGE = 5'h1F;
  localparam logic [1:0] USER_RESET = 2'h0;
  localparam logic [MAP_W-1:0] MAP_RESET = 3'h0;
  localparam logic [15:0] ACC_RESET = 16'h0000;
  // ==========================================================
  // Translation modes
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_PENDING,
    MODE_ON,
    MODE_ONESHOT
  } mmsp_mode_t;
endpackage : mmsp_pkg

// File: hdl/mmsp_flag.sv
// Sticky flag whose set wins over its clear
`timescale 1ns/1ns
module mmsp_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic set,
  input wire logic clr,
  // State
  output logic q
);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= 1'b0;
    else if (set)
      q <= 1'b1;
    else if (clr)
      q <= 1'b0;
  end
endmodule : mmsp_flag

// File: hdl/mmsp_map_ram.sv
// Translation table: eight maps of 32 pages, one write and two read ports
`timescale 1ns/1ns
module mmsp_map_ram #(
  parameter int MAP_W = 3,
  parameter int PAGE_W = 5,
  parameter int ENTRY_W = 11
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [MAP_W-1:0] wr_map,
  input wire logic [PAGE_W-1:0] wr_page,
  input wire logic [ENTRY_W-1:0] wr_data,
  // Translation read port
  input wire logic [MAP_W-1:0] a_map,
  input wire logic [PAGE_W-1:0] a_page,
  output logic [ENTRY_W-1:0] a_data,
  // Page-check read port
  input wire logic [MAP_W-1:0] b_map,
  input wire logic [PAGE_W-1:0] b_page,
  output logic [ENTRY_W-1:0] b_data
);
  logic [ENTRY_W-1:0] mem [0:(1<<(MAP_W+PAGE_W))-1];

  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[{wr_map, wr_page}] <= wr_data;
  end

  assign a_data = mem[{a_map, a_page}];
  assign b_data = mem[{b_map, b_page}];
endmodule : mmsp_map_ram

// File: hdl/mmsp_status_page_check.sv
// Address translation status word, page check and page-31 remapping
`timescale 1ns/1ns
module mmsp_status_page_check (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // I/O-format instruction strobes
  input wire logic status_read_op,
  input wire logic status_write_op,
  input wire logic page_check_select_op,
  input wire logic page_check_read_op,
  input wire logic page31_load_op,
  input wire logic single_cycle_op,
  input wire logic io_reset_op,
  // Table load, one word per strobe
  input wire logic table_load_op,
  // Accumulator in
  input wire logic [15:0] acc_in,
  // Processor events
  input wire logic resume_event,
  input wire logic ldst_done,
  input wire logic irq_taken,
  // Memory reference
  input wire logic ref_valid,
  input wire logic [14:0] ref_addr,
  input wire logic ref_is_write,
  input wire logic ref_is_indirect,
  input wire logic ref_first_ldst,
  input wire logic ref_is_chan,
  input wire logic [1:0] ref_chan_id,
  // Accumulator out
  output logic [15:0] acc_out,
  output logic acc_out_valid,
  // Translated reference
  output logic [19:0] phys_addr,
  output logic phys_valid,
  output logic map_fault,
  // Interrupt hold-off
  output logic irq_inhibit
);
  // ==========================================================
  // State
  mmsp_pkg::mmsp_mode_t mode_reg;
  mmsp_pkg::mmsp_mode_t mode_next;
  logic [1:0] user_reg;
  logic [3:0] prot_reg;
  logic [mmsp_pkg::MAP_W-1:0] map_sel_reg;
  logic [mmsp_pkg::PAGE_W-1:0] sel_page_reg;
  logic [mmsp_pkg::PHYS_W-1:0] p31_reg;
  logic dch_reg;
  logic um_reg;
  logic sc_reg;
  logic sc_inh;
  logic f_io;
  logic f_wp;
  logic f_ind;

  // ==========================================================
  // Access gating
  wire xlate_on_flag = (mode_reg == mmsp_pkg::MODE_ON);
  wire load_effective_mode = prot_reg[3];
  wire io_protect = prot_reg[2];
  wire wr_protect = prot_reg[1];
  wire deref_protect = prot_reg[0];
  wire ops_ok = ~xlate_on_flag | (~load_effective_mode & ~io_protect);
  wire io_any = status_read_op | status_write_op | page_check_select_op | page_check_read_op
    | page31_load_op | single_cycle_op;
  wire do_stat_wr = status_write_op & ops_ok;
  wire do_sel = page_check_select_op & ops_ok;
  wire do_single = single_cycle_op & ops_ok;
  wire do_p31 = page31_load_op & ~xlate_on_flag;
  wire do_tbl = table_load_op & ~(xlate_on_flag & io_protect);
  wire io_fault = xlate_on_flag & io_protect
    & (table_load_op | (io_any & ~load_effective_mode));

  // ==========================================================
  // Reference translation
  wire [mmsp_pkg::PAGE_W-1:0] ref_page = ref_addr[14:10];
  wire [mmsp_pkg::OFFS_W-1:0] ref_offs = ref_addr[9:0];
  wire one_shot_hit = (mode_reg == mmsp_pkg::MODE_ONESHOT) & ref_first_ldst;
  wire use_user = ref_valid & ~ref_is_chan & (xlate_on_flag | one_shot_hit);
  wire use_chan = ref_valid & ref_is_chan & dch_reg;
  // User code {b0,b13} maps to map code {0,b13,b0}
  wire [mmsp_pkg::MAP_W-1:0] user_map = {1'b0, user_reg[0], user_reg[1]};
  wire [mmsp_pkg::MAP_W-1:0] chan_map = {1'b1, ref_chan_id[0], ref_chan_id[1]};
  wire [mmsp_pkg::MAP_W-1:0] xl_map = use_chan ? chan_map : user_map;
  wire [mmsp_pkg::ENTRY_W-1:0] xl_entry;
  wire xl_wp = xl_entry[mmsp_pkg::ENTRY_W-1];
  wire [mmsp_pkg::PHYS_W-1:0] xl_phys = xl_entry[mmsp_pkg::PHYS_W-1:0];
  wire xl_invalid = &xl_entry;
  wire wp_fault = use_user & wr_protect & ref_is_write & xl_wp;
  wire ind_fault = use_user & deref_protect & ref_is_indirect;
  wire val_fault = use_user & xl_invalid;
  wire ref_fault = wp_fault | ind_fault | val_fault;
  // Page 31 remap looked up live, so a new target takes effect at once
  wire [mmsp_pkg::PHYS_W-1:0] raw_phys = (ref_page == mmsp_pkg::P31_PAGE) ? p31_reg
    : {{(mmsp_pkg::PHYS_W-mmsp_pkg::PAGE_W){1'b0}}, ref_page};
  wire [mmsp_pkg::PHYS_W-1:0] out_phys = (use_user | use_chan) ? xl_phys : raw_phys;

  // ==========================================================
  // Page check lookup
  wire [mmsp_pkg::ENTRY_W-1:0] pc_entry;
  wire [15:0] pc_result = {pc_entry[mmsp_pkg::ENTRY_W-1], map_sel_reg, 2'b00,
    pc_entry[mmsp_pkg::PHYS_W-1:0]};

  // ==========================================================
  // Status word
  wire [15:0] status_word = {user_reg[1], xlate_on_flag, f_io, f_wp, f_ind, sc_reg,
    map_sel_reg, prot_reg, user_reg[0], dch_reg, um_reg};

  // ==========================================================
  // Table and fault flags
  mmsp_map_ram #(
    .MAP_W(mmsp_pkg::MAP_W),
    .PAGE_W(mmsp_pkg::PAGE_W),
    .ENTRY_W(mmsp_pkg::ENTRY_W)
  ) u_ram (
    .clk(sys_clk),
    .wr_en(do_tbl),
    .wr_map(map_sel_reg),
    .wr_page(acc_in[mmsp_pkg::PG_HI:mmsp_pkg::PG_LO]),
    .wr_data({acc_in[mmsp_pkg::WORD_WP], acc_in[mmsp_pkg::PHYS_HI:0]}),
    .a_map(xl_map),
    .a_page(ref_page),
    .a_data(xl_entry),
    .b_map(map_sel_reg),
    .b_page(sel_page_reg),
    .b_data(pc_entry)
  );

  // Latest fault type only; a new fault of another kind clears the others
  mmsp_flag u_fio (
    .clk(sys_clk),
    .rst_b(rst_b),
    .set(io_fault),
    .clr(wp_fault | ind_fault | io_reset_op),
    .q(f_io)
  );
  mmsp_flag u_fwp (
    .clk(sys_clk),
    .rst_b(rst_b),
    .set(wp_fault & ~ind_fault),
    .clr(io_fault | ind_fault | io_reset_op),
    .q(f_wp)
  );
  mmsp_flag u_find (
    .clk(sys_clk),
    .rst_b(rst_b),
    .set(ind_fault),
    .clr(io_fault | wp_fault | io_reset_op),
    .q(f_ind)
  );
  mmsp_flag u_scinh (
    .clk(sys_clk),
    .rst_b(rst_b),
    .set(do_single),
    .clr(ldst_done | io_reset_op),
    .q(sc_inh)
  );

  // ==========================================================
  // Mode sequencing
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      mmsp_pkg::MODE_OFF:
      begin
        if (do_stat_wr && acc_in[mmsp_pkg::ST_UE])
          mode_next = mmsp_pkg::MODE_PENDING;
        else if (do_single)
          mode_next = mmsp_pkg::MODE_ONESHOT;
      end
      mmsp_pkg::MODE_PENDING:
      begin
        if (do_stat_wr && !acc_in[mmsp_pkg::ST_UE])
          mode_next = mmsp_pkg::MODE_OFF;
        else if (resume_event)
          mode_next = mmsp_pkg::MODE_ON;
      end
      mmsp_pkg::MODE_ON:
      begin
        if (do_single)
          mode_next = mmsp_pkg::MODE_OFF;
        else if (do_stat_wr && !acc_in[mmsp_pkg::ST_UE])
          mode_next = mmsp_pkg::MODE_OFF;
      end
      mmsp_pkg::MODE_ONESHOT:
      begin
        if (do_stat_wr)
          mode_next = acc_in[mmsp_pkg::ST_UE] ? mmsp_pkg::MODE_PENDING : mmsp_pkg::MODE_OFF;
        else if (ref_valid && one_shot_hit)
          mode_next = mmsp_pkg::MODE_OFF;
      end
      default:
        mode_next = mmsp_pkg::MODE_OFF;
    endcase
    if (io_reset_op)
      mode_next = mmsp_pkg::MODE_OFF;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_reg <= mmsp_pkg::MODE_OFF;
    else
      mode_reg <= mode_next;
  end

  // ==========================================================
  // Status fields written by software
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      user_reg <= mmsp_pkg::USER_RESET;
      prot_reg <= 4'h0;
      dch_reg <= 1'b0;
    end
    else if (io_reset_op)
    begin
      user_reg <= mmsp_pkg::USER_RESET;
      dch_reg <= 1'b0;
    end
    else if (do_stat_wr)
    begin
      user_reg <= {acc_in[mmsp_pkg::ST_USER_HI], acc_in[mmsp_pkg::ST_USER_LO]};
      prot_reg <= acc_in[mmsp_pkg::ST_LEF:mmsp_pkg::ST_INDE];
      dch_reg <= acc_in[mmsp_pkg::ST_DCH];
    end
  end

  // Map selector shared by status write, page-check select and table load
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      map_sel_reg <= mmsp_pkg::MAP_RESET;
    else if (do_stat_wr || do_sel)
      map_sel_reg <= acc_in[mmsp_pkg::ST_MAP_HI:mmsp_pkg::ST_MAP_LO];
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      sel_page_reg <= '0;
    else if (do_sel)
      sel_page_reg <= acc_in[mmsp_pkg::PG_HI:mmsp_pkg::PG_LO];
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      p31_reg <= mmsp_pkg::P31_RESET;
    else if (io_reset_op)
      p31_reg <= mmsp_pkg::P31_RESET;
    else if (do_p31)
      p31_reg <= acc_in[mmsp_pkg::PHYS_HI:0];
  end

  // ==========================================================
  // Status fields set by hardware
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sc_reg <= 1'b0;
      um_reg <= 1'b0;
    end
    else
    begin
      if (use_user)
        sc_reg <= one_shot_hit & ~xlate_on_flag;
      else if (io_reset_op)
        sc_reg <= 1'b0;
      if (irq_taken)
        um_reg <= xlate_on_flag;
      else if (io_reset_op)
        um_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_out <= mmsp_pkg::ACC_RESET;
      acc_out_valid <= 1'b0;
    end
    else
    begin
      acc_out_valid <= (status_read_op | page_check_read_op) & ops_ok;
      if (status_read_op && ops_ok)
        acc_out <= status_word;
      else if (page_check_read_op && ops_ok)
        acc_out <= pc_result;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phys_addr <= 20'h0_0000;
      phys_valid <= 1'b0;
      map_fault <= 1'b0;
      irq_inhibit <= 1'b0;
    end
    else
    begin
      if (ref_valid)
        phys_addr <= {out_phys, ref_offs};
      phys_valid <= ref_valid & ~ref_fault;
      map_fault <= (ref_valid & ref_fault) | io_fault;
      irq_inhibit <= (sc_inh & ~ldst_done & ~io_reset_op) | do_single
        | (mode_next == mmsp_pkg::MODE_PENDING);
    end
  end
endmodule : mmsp_status_page_check

// File: sim/mmsp_assertions.sv
// Concurrent checks on the status and page-check block ports
`timescale 1ns/1ns
module mmsp_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Requests
  input wire logic status_read_op,
  input wire logic status_write_op,
  input wire logic page_check_read_op,
  input wire logic page31_load_op,
  input wire logic single_cycle_op,
  input wire logic io_reset_op,
  input wire logic ldst_done,
  input wire logic [15:0] acc_in,
  input wire logic ref_valid,
  input wire logic [14:0] ref_addr,
  input wire logic ref_first_ldst,
  // Answers
  input wire logic [15:0] acc_out,
  input wire logic acc_out_valid,
  input wire logic [19:0] phys_addr,
  input wire logic phys_valid,
  input wire logic map_fault,
  input wire logic irq_inhibit
);
  wire logic [9:0] p31_req = acc_in[9:0];
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Assertions
  a_read_cause: assert property (
    acc_out_valid |-> $past(status_read_op | page_check_read_op))
    else $error("read answer without a read");
  a_rsvd_zero: assert property (
    acc_out_valid && $past(page_check_read_op) |-> acc_out[11:10] == 2'h0)
    else $error("page check reserved bits set");
  a_reset_clear: assert property (
    io_reset_op ##1 !status_write_op ##1 status_read_op
    |=> acc_out[15:10] == 6'h00 && acc_out[2:0] == 3'h0)
    else $error("status not cleared by io reset");
  a_no_both: assert property (!(phys_valid && map_fault))
    else $error("valid and fault together");
  a_pass_through: assert property (
    io_reset_op ##1 !single_cycle_op ##1 (ref_valid && ref_addr[14:10] != 5'h1F)
    |=> phys_valid && phys_addr == {5'h00, $past(ref_addr)})
    else $error("page not passed through");
  a_p31_ident: assert property (
    io_reset_op ##1 !(single_cycle_op || page31_load_op)
    ##1 (ref_valid && ref_addr[14:10] == 5'h1F) |=> phys_addr[19:10] == 10'h01F)
    else $error("page 31 not identity");
  a_p31_new: assert property (
    io_reset_op ##1 !(single_cycle_op || status_write_op) ##1 page31_load_op
    ##1 !(single_cycle_op || page31_load_op || io_reset_op)
    ##1 (ref_valid && ref_addr[14:10] == 5'h1F) |=> phys_addr[19:10] == $past(p31_req, 3))
    else $error("page 31 target not applied");
  a_sc_inhibit: assert property (
    io_reset_op ##1 !status_write_op ##1 single_cycle_op
    ##1 (!ldst_done && !io_reset_op && !status_write_op) [*5]
    ##1 (ldst_done && !status_write_op && !single_cycle_op) |-> irq_inhibit ##1 !irq_inhibit)
    else $error("interrupt hold wrong");
  a_sc_second: assert property (
    io_reset_op ##1 !status_write_op ##1 single_cycle_op ##1 !status_write_op
    ##1 (ref_valid && ref_first_ldst && !status_write_op)
    ##1 !(single_cycle_op || status_write_op)
    ##1 (ref_valid && ref_addr[14:10] != 5'h1F) |=> phys_addr == {5'h00, $past(ref_addr)})
    else $error("second reference translated");
  c_single: cover property (io_reset_op ##2 single_cycle_op);
  c_fault: cover property (map_fault);
  c_read: cover property (acc_out_valid);
endmodule : mmsp_assertions

// File: sim/mmsp_cpu.sv
// Processor core model issuing instructions and memory references
`timescale 1ns/1ns
module mmsp_cpu (
  // Clock
  input wire logic sys_clk,
  // Instruction strobes and accumulator
  output logic [10:0] ops,
  output logic [15:0] acc_in,
  // Memory reference
  output logic ref_valid,
  output logic [14:0] ref_addr,
  output logic ref_is_write,
  output logic ref_is_indirect,
  output logic ref_first_ldst,
  // Answers
  input wire logic [15:0] acc_out,
  input wire logic acc_out_valid,
  input wire logic [19:0] phys_addr,
  input wire logic phys_valid,
  input wire logic map_fault
);
  initial
  begin
    ops = 11'h000;
    acc_in = 16'h0000;
    ref_valid = 1'b0;
    ref_addr = 15'h0000;
    {ref_is_write, ref_is_indirect, ref_first_ldst} = 3'h0;
  end
  // One instruction, then one idle edge; released values are inverted
  task automatic op(input int k, input logic [15:0] v, output logic [15:0] q, output logic qv);
    ops[k] = 1'b1;
    acc_in = v;
    @(posedge sys_clk);
    #1;
    q = acc_out;
    qv = acc_out_valid;
    #4;
    ops[k] = 1'b0;
    acc_in = ~v;
    @(posedge sys_clk);
    #5;
  endtask : op
  task automatic mref(input logic [14:0] a, input logic [2:0] f, output logic [19:0] p,
    output logic [1:0] r);
    ref_valid = 1'b1;
    ref_addr = a;
    {ref_is_write, ref_is_indirect, ref_first_ldst} = f;
    @(posedge sys_clk);
    #1;
    p = phys_addr;
    r = {phys_valid, map_fault};
    #4;
    ref_valid = 1'b0;
    ref_addr = ~a;
    {ref_is_write, ref_is_indirect, ref_first_ldst} = ~f;
    @(posedge sys_clk);
    #5;
  endtask : mref
endmodule : mmsp_cpu

// File: sim/mmsp_tb.sv
// Self-checking bench for the status and page-check block
`timescale 1ns/1ns
module testbench;
  localparam int SR = 0, SW = 1, PS = 2, PR = 3, P31 = 4, SC = 5, IOR = 6, TL = 7;
  localparam int RES = 8, LD = 9, IRQ = 10;
  logic sys_clk;
  logic rst_b;
  logic [10:0] ops;
  logic [15:0] acc_in;
  logic [15:0] acc_out;
  logic [14:0] ref_addr;
  logic [19:0] phys_addr;
  logic ref_valid, ref_is_write, ref_is_indirect, ref_first_ldst;
  logic acc_out_valid, phys_valid, map_fault, irq_inhibit;
  logic [15:0] q;
  logic qv;
  logic [19:0] p;
  logic [1:0] r;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  mmsp_cpu cpu (.sys_clk, .ops, .acc_in, .ref_valid, .ref_addr, .ref_is_write,
    .ref_is_indirect, .ref_first_ldst, .acc_out, .acc_out_valid, .phys_addr,
    .phys_valid, .map_fault);
  mmsp_status_page_check uut (
    .sys_clk, .rst_b,
    .status_read_op(ops[0]), .status_write_op(ops[1]), .page_check_select_op(ops[2]),
    .page_check_read_op(ops[3]), .page31_load_op(ops[4]), .single_cycle_op(ops[5]),
    .io_reset_op(ops[6]), .table_load_op(ops[7]), .acc_in,
    .resume_event(ops[8]), .ldst_done(ops[9]), .irq_taken(ops[10]),
    .ref_valid, .ref_addr, .ref_is_write, .ref_is_indirect, .ref_first_ldst,
    .ref_is_chan(1'b0), .ref_chan_id(2'h0),
    .acc_out, .acc_out_valid, .phys_addr, .phys_valid, .map_fault, .irq_inhibit
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic cmp(input string n, input logic [19:0] e, input logic [19:0] s);
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic w(input int k, input logic [15:0] v);
    cpu.op(k, v, q, qv);
  endtask : w
  task automatic rd(input int k, input logic [15:0] e);
    cpu.op(k, 16'h0000, q, qv);
    cmp("read valid", 20'h0_0001, {19'h0, qv});
    cmp("read word", {4'h0, e}, {4'h0, q});
  endtask : rd
  task automatic m(input logic [14:0] a, input logic [2:0] f, input logic [19:0] e,
    input logic [1:0] er);
    cpu.mref(a, f, p, r);
    cmp("ref flags", {18'h0, er}, {18'h0, r});
    if (er == 2'h2)
      cmp("phys addr", e, p);
  endtask : m
  task automatic ih(input logic e);
    cmp("irq hold", {19'h0, e}, {19'h0, irq_inhibit});
  endtask : ih
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  initial
  begin
    logic [15:0] v;
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #5;
    rst_b = 1'b1;
    // ==========================================================
    // Status word fields for every user and map code
    for (int i = 0; i < 8; i++)
    begin
      v = {i[1], 5'h00, i[2:0], 4'h1 << i[1:0], i[0], i[2], 1'b0};
      w(SW, v);
      rd(SR, v);
    end
    $display("test status fields done");
    // ==========================================================
    // Table load and page check
    w(SW, 16'h0000);
    w(TL, 16'h9523);
    @(posedge sys_clk);
    #5;
    w(TL, 16'h9BFF);
    @(posedge sys_clk);
    #5;
    w(TL, 16'h10F0);
    w(PS, 16'h1400);
    rd(PR, 16'h8123);
    w(PS, 16'h1000);
    rd(PR, 16'h00F0);
    $display("test page check done");
    // ==========================================================
    // Untranslated page 31 remapping
    w(IOR, 16'h0000);
    w(P31, 16'h02AA);
    m(15'h7C3F, 3'h0, 20'hA_A83F, 2'h2);
    m(15'h1407, 3'h0, 20'h0_1407, 2'h2);
    w(IOR, 16'h0000);
    m(15'h7C3F, 3'h0, 20'h0_7C3F, 2'h2);
    w(IOR, 16'h0000);
    m(15'h1407, 3'h0, 20'h0_1407, 2'h2);
    $display("test page 31 done");
    // ==========================================================
    // Single mapped reference from unmapped mode
    w(IOR, 16'h0000);
    w(SC, 16'h0000);
    ih(1'b1);
    m(15'h1407, 3'h3, 20'h4_8C07, 2'h2);
    m(15'h1407, 3'h1, 20'h0_1407, 2'h2);
    ih(1'b1);
    w(LD, 16'h0000);
    ih(1'b0);
    rd(SR, 16'h0400);
    // User C single reference through map C
    w(SW, 16'h8080);
    w(TL, 16'h1555);
    w(SC, 16'h0000);
    m(15'h1407, 3'h1, 20'h5_5407, 2'h2);
    w(LD, 16'h0000);
    $display("test single cycle done");
    // ==========================================================
    // Translation on, faults, user-mode single cycle
    w(SW, 16'h0019);
    ih(1'b1);
    w(RES, 16'h0000);
    m(15'h1007, 3'h0, 20'h3_C007, 2'h2);
    m(15'h1007, 3'h2, 20'h0_0000, 2'h1);
    rd(SR, 16'h4818);
    m(15'h1807, 3'h0, 20'h0_0000, 2'h1);
    m(15'h1407, 3'h4, 20'h0_0000, 2'h1);
    w(IRQ, 16'h0000);
    rd(SR, 16'h5019);
    w(SC, 16'h0000);
    w(SR, 16'h0000);
    cmp("map on", 20'h0_0000, {19'h0, q[14]});
    m(15'h1407, 3'h0, 20'h0_1407, 2'h2);
    w(IOR, 16'h0000);
    rd(SR, 16'h0018);
    $display("test translation done");
    wrap_up();
  end
endmodule : testbench
bind mmsp_status_page_check mmsp_assertions chk (
  .sys_clk, .rst_b, .status_read_op, .status_write_op, .page_check_read_op, .page31_load_op,
  .single_cycle_op, .io_reset_op, .ldst_done, .acc_in, .ref_valid, .ref_addr, .ref_first_ldst,
  .acc_out, .acc_out_valid, .phys_addr, .phys_valid, .map_fault, .irq_inhibit
);
